//--- core/tpdf_top.v
// Triple-port dual FIFO with mailboxes, loopback and programmable flags
// How it works
// - Each port clock is sampled separately; its rising edge times that port.
// - Two 18-bit mailboxes pass words between ports, bypassing the queues.
// - Each mailbox raises its new flag when a word is stored.
// - Master reset clears both pointers and latches the offset programming choice.
// - Partial reset clears pointers but keeps method and offsets.
// - Replay mode with the shared input rewinds only the read pointer.
// - Standard timing: data reaches outputs only after a read.
// - Fall-through timing: first word appears unrequested; later words need reads.
// - Timing mode comes from the endian/timing select input around master reset.
// - After master reset high selects standard, low fall-through; level stays.
// - During master reset high selects big-endian, low little-endian ordering.
// - Combined flags mean empty/full in standard, output/input ready in fall-through.
// - Almost-full tracks free room; almost-empty tracks remaining words.
// - Almost-empty is low while stored words do not exceed its offset.
// - Full and almost-full pass two stages on the writing port clock.
// - Empty and almost-empty pass two stages on the reading port clock.
// - Offsets load in parallel over port A or serially from one input.
// - Offset select picks method or default 8, 16, 64, 256, 1024.
// - With interspersed parity, bit 8 is skipped in parallel offset words.
// - Loopback moves second-queue words into first; read direction also drives A.
// - Loopback with A writing does not drive port A lines.
// - Loopback fills the first queue while it has room and the second has data or a held last word.
// - First queue full: loop words go only to port A when reading.
// - Second queue empty: its last word keeps filling the first queue.
`include "tpdf_defines.vh"
`default_nettype none

module tpdf_queue (
	input  wire                   clk_i,
	input  wire                   rst_n_i,
	input  wire                   init_i,
	input  wire                   replay_i,
	input  wire                   ft_mode_i,
	input  wire                   wr_i,
	input  wire [`TPDF_WIDTH-1:0] wr_data_i,
	input  wire                   rd_i,
	input  wire [`TPDF_CW-1:0]    ae_off_i,
	input  wire [`TPDF_CW-1:0]    af_off_i,
	output wire [`TPDF_WIDTH-1:0] take_o,
	output wire [`TPDF_WIDTH-1:0] dout_o,
	output wire                   ready_o,
	output wire                   room_o,
	output wire                   ae_n_o,
	output wire                   af_n_o
);
	reg  [`TPDF_WIDTH-1:0] mem [0:`TPDF_DEPTH-1];
	reg  [`TPDF_AW-1:0]    wr_q;
	reg  [`TPDF_AW-1:0]    rd_q;
	reg  [`TPDF_CW-1:0]    count_q;
	reg  [`TPDF_WIDTH-1:0] dout_q;
	reg                    ov_q;
	wire                   mem_empty = (count_q == {`TPDF_CW{1'b0}});
	wire                   full      = (count_q == `TPDF_DEPTH);
	wire                   do_wr     = wr_i & ~full;
	// Standard loads only on a read; fall-through preloads an idle output
	wire                   load = ~mem_empty & (ft_mode_i ? (~ov_q | rd_i) : rd_i);
	wire [`TPDF_CW-1:0]    level = count_q + {{(`TPDF_CW-1){1'b0}}, ft_mode_i & ov_q};

	assign take_o  = ft_mode_i ? dout_q : mem[rd_q];
	assign dout_o  = dout_q;
	assign ready_o = ft_mode_i ? ov_q : ~mem_empty;
	assign room_o  = ~full;
	assign ae_n_o  = (level > ae_off_i);
	assign af_n_o  = ((`TPDF_DEPTH - count_q) > af_off_i);

	always @(posedge clk_i) begin
		if (do_wr)
			mem[wr_q] <= wr_data_i;
	end

	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr_q    <= {`TPDF_AW{1'b0}};
			rd_q    <= {`TPDF_AW{1'b0}};
			count_q <= {`TPDF_CW{1'b0}};
			dout_q  <= {`TPDF_WIDTH{1'b0}};
			ov_q    <= 1'b0;
		end else if (init_i) begin
			wr_q    <= {`TPDF_AW{1'b0}};
			rd_q    <= {`TPDF_AW{1'b0}};
			count_q <= {`TPDF_CW{1'b0}};
			ov_q    <= 1'b0;
		end else if (replay_i) begin
			rd_q    <= {`TPDF_AW{1'b0}};
			count_q <= full ? `TPDF_DEPTH : {1'b0, wr_q};
			ov_q    <= 1'b0;
		end else begin
			if (do_wr)
				wr_q <= wr_q + 1'b1;
			if (load) begin
				rd_q   <= rd_q + 1'b1;
				dout_q <= mem[rd_q];
			end
			count_q <= count_q + {{(`TPDF_CW-1){1'b0}}, do_wr}
				- {{(`TPDF_CW-1){1'b0}}, load};
			if (ft_mode_i)
				ov_q <= load | (ov_q & ~rd_i);
		end
	end
endmodule // tpdf_queue

module tpdf_top (
	input  wire                   clock_i,
	input  wire                   reset_n_i,
	input  wire                   port_a_clk_i,
	input  wire                   port_b_clk_i,
	input  wire                   port_c_clk_i,
	input  wire                   full_init_first_queue_n_i,
	input  wire                   full_init_second_queue_n_i,
	input  wire                   flush_first_queue_n_i,
	input  wire                   flush_second_queue_n_i,
	input  wire                   replay_mode_select_i,
	input  wire                   endian_timing_select_i,
	input  wire                   offset_select_bit0_i,
	input  wire                   offset_select_bit1_i,
	input  wire                   offset_select_bit2_i,
	input  wire                   parity_select_i,
	input  wire                   serial_offset_input_i,
	input  wire                   serial_enable_i,
	input  wire                   loop_select_i,
	input  wire                   port_a_direction_i,
	input  wire                   port_a_enable_i,
	input  wire                   port_a_mailbox_i,
	input  wire [`TPDF_WIDTH-1:0] port_a_data_i,
	output reg  [`TPDF_WIDTH-1:0] port_a_data_o,
	output reg                    port_a_data_oe_n_o,
	input  wire                   port_b_enable_i,
	input  wire                   port_b_mailbox_i,
	output reg  [`TPDF_HALF-1:0]  port_b_data_o,
	input  wire                   port_c_enable_i,
	input  wire                   port_c_mailbox_i,
	input  wire [`TPDF_HALF-1:0]  port_c_data_i,
	output wire                   a_side_full_ready_o,
	output wire                   a_side_almost_full_o,
	output wire                   a_side_empty_ready_o,
	output wire                   a_side_almost_empty_o,
	output wire                   b_side_empty_ready_o,
	output wire                   b_side_almost_empty_o,
	output wire                   c_side_full_ready_o,
	output wire                   c_side_almost_full_o,
	output reg                    mailbox_one_new_flag_o,
	output reg                    mailbox_two_new_flag_o
);
	function [`TPDF_CW-1:0] tpdf_default;
		input [2:0] fs;
		begin
			case (fs)
			`TPDF_FS_8:    tpdf_default = `TPDF_OFF_8;
			`TPDF_FS_16:   tpdf_default = `TPDF_OFF_16;
			`TPDF_FS_64:   tpdf_default = `TPDF_OFF_64;
			`TPDF_FS_256:  tpdf_default = `TPDF_OFF_256;
			default:       tpdf_default = `TPDF_OFF_1024;
			endcase
		end
	endfunction

	// Pin synchroniser: {clka,clkb,clkc,init1,init2,flush1,flush2}
	reg  [6:0] s1_q, s2_q, s3_q, pin_q;
	reg  [2:0] clk_prev_q;
	wire [6:0] pins = {port_a_clk_i, port_b_clk_i, port_c_clk_i,
		full_init_first_queue_n_i, full_init_second_queue_n_i,
		flush_first_queue_n_i, flush_second_queue_n_i};
	always @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			s1_q       <= 7'h00;
			s2_q       <= 7'h00;
			s3_q       <= 7'h00;
			pin_q      <= 7'h00;
			clk_prev_q <= 3'h0;
		end else begin
			s1_q       <= pins;
			s2_q       <= s1_q;
			s3_q       <= s2_q;
			// A change counts once stages two and three agree
			pin_q      <= (s2_q & s3_q) | (pin_q & (s2_q | s3_q));
			clk_prev_q <= pin_q[6:4];
		end
	end
	wire a_edge = pin_q[6] & ~clk_prev_q[2];
	wire b_edge = pin_q[5] & ~clk_prev_q[1];
	wire c_edge = pin_q[4] & ~clk_prev_q[0];
	wire init1  = ~pin_q[3];
	wire init2  = ~pin_q[2];
	wire shared1 = ~pin_q[1];
	wire shared2 = ~pin_q[0];
	wire [2:0] fs = {offset_select_bit2_i, offset_select_bit1_i, offset_select_bit0_i};

	// Configuration latched around master reset
	reg                    ft_mode_q, big_q, parity_q, serial_q;
	reg  [5:0]             prog_q;
	reg  [4*`TPDF_CW-1:0]  offs_q; // {af2, ae2, af1, ae1}
	wire prog_done = serial_q ? (prog_q == `TPDF_SER_STEPS) : (prog_q == `TPDF_PAR_STEPS);
	wire a_wr  = a_edge & port_a_direction_i & port_a_enable_i & ~port_a_mailbox_i;
	wire [`TPDF_CW-1:0] par_word = parity_q ? {port_a_data_i[12:9], port_a_data_i[7:0]}
		: port_a_data_i[`TPDF_CW-1:0];
	always @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ft_mode_q <= 1'b0;
			big_q    <= 1'b0;
			parity_q <= 1'b0;
			serial_q <= 1'b0;
			prog_q   <= `TPDF_PAR_STEPS;
			offs_q   <= {4{`TPDF_OFF_8}};
		end else if (init1 | init2) begin
			big_q    <= endian_timing_select_i;
			parity_q <= parity_select_i;
			serial_q <= (fs == `TPDF_FS_SERIAL);
			if (fs == `TPDF_FS_SERIAL || fs > `TPDF_FS_SERIAL)
				prog_q <= 6'h00;
			else
				prog_q <= `TPDF_PAR_STEPS;
			if (init1)
				offs_q[2*`TPDF_CW-1:0] <= {2{tpdf_default(fs)}};
			if (init2)
				offs_q[4*`TPDF_CW-1:2*`TPDF_CW] <= {2{tpdf_default(fs)}};
		end else begin
			ft_mode_q <= ~endian_timing_select_i;
			if (!prog_done && serial_q && a_edge && serial_enable_i) begin
				offs_q <= {serial_offset_input_i, offs_q[4*`TPDF_CW-1:1]};
				prog_q <= prog_q + 6'h01;
			end else if (!prog_done && !serial_q && a_wr) begin
				offs_q <= {par_word, offs_q[4*`TPDF_CW-1:`TPDF_CW]};
				prog_q <= prog_q + 6'h01;
			end
		end
	end

	// Queue controls; shared flush/replay input splits on replay mode
	wire                   rdy1, room1, ae1, af1, rdy2, room2, ae2, af2;
	wire [`TPDF_WIDTH-1:0] take1, take2, dout1, dout2;
	reg  [`TPDF_WIDTH-1:0] last_q;
	reg                    last_v_q;
	wire a_read_dir = ~port_a_direction_i;
	// Loop pops only where the word has somewhere to go
	wire lp_pop  = loop_select_i & a_edge & rdy2 & (room1 | a_read_dir);
	wire lp_push = loop_select_i & a_edge & room1 & (rdy2 | last_v_q);
	wire pop2 = loop_select_i ? lp_pop
		: (a_edge & a_read_dir & port_a_enable_i & ~port_a_mailbox_i);
	wire push1 = loop_select_i ? lp_push : (a_wr & prog_done);
	wire [`TPDF_WIDTH-1:0] push1_data = loop_select_i ? (rdy2 ? take2 : last_q) : port_a_data_i;
	wire pop1 = b_edge & port_b_enable_i & ~port_b_mailbox_i;
	wire push2 = c_edge & port_c_enable_i & ~port_c_mailbox_i;
	wire [`TPDF_WIDTH-1:0] push2_data = big_q ? {port_c_data_i, {`TPDF_HALF{1'b0}}}
		: {{`TPDF_HALF{1'b0}}, port_c_data_i};

	tpdf_queue u_first (
		.clk_i     (clock_i),
		.rst_n_i   (reset_n_i),
		.init_i    (init1 | (shared1 & ~replay_mode_select_i)),
		.replay_i  (shared1 & replay_mode_select_i),
		.ft_mode_i (ft_mode_q),
		.wr_i      (push1),
		.wr_data_i (push1_data),
		.rd_i      (pop1),
		.ae_off_i  (offs_q[`TPDF_CW-1:0]),
		.af_off_i  (offs_q[2*`TPDF_CW-1:`TPDF_CW]),
		.take_o    (take1),
		.dout_o    (dout1),
		.ready_o   (rdy1),
		.room_o    (room1),
		.ae_n_o    (ae1),
		.af_n_o    (af1)
	);

	tpdf_queue u_second (
		.clk_i     (clock_i),
		.rst_n_i   (reset_n_i),
		.init_i    (init2 | (shared2 & ~replay_mode_select_i)),
		.replay_i  (shared2 & replay_mode_select_i),
		.ft_mode_i (ft_mode_q),
		.wr_i      (push2),
		.wr_data_i (push2_data),
		.rd_i      (pop2),
		.ae_off_i  (offs_q[3*`TPDF_CW-1:2*`TPDF_CW]),
		.af_off_i  (offs_q[4*`TPDF_CW-1:3*`TPDF_CW]),
		.take_o    (take2),
		.dout_o    (dout2),
		.ready_o   (rdy2),
		.room_o    (room2),
		.ae_n_o    (ae2),
		.af_n_o    (af2)
	);

	// Flags: two stages on the clock of the port that uses them
	reg [3:0] fa1_q, fa2_q;
	reg [1:0] fb1_q, fb2_q, fc1_q, fc2_q;
	assign a_side_full_ready_o   = fa2_q[3];
	assign a_side_almost_full_o  = fa2_q[2];
	assign a_side_empty_ready_o  = fa2_q[1];
	assign a_side_almost_empty_o = fa2_q[0];
	assign b_side_empty_ready_o  = fb2_q[1];
	assign b_side_almost_empty_o = fb2_q[0];
	assign c_side_full_ready_o   = fc2_q[1];
	assign c_side_almost_full_o  = fc2_q[0];

	reg [`TPDF_HALF-1:0] mbx1_q, mbx2_q;
	wire a_mbx_rd = a_edge & a_read_dir & port_a_enable_i & port_a_mailbox_i;
	wire a_mbx_wr = a_edge & port_a_direction_i & port_a_enable_i & port_a_mailbox_i;
	wire b_mbx_rd = b_edge & port_b_enable_i & port_b_mailbox_i;
	wire c_mbx_wr = c_edge & port_c_enable_i & port_c_mailbox_i;

	always @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			fa1_q <= 4'hC;
			fa2_q <= 4'hC;
			fb1_q <= 2'h0;
			fb2_q <= 2'h0;
			fc1_q <= 2'h3;
			fc2_q <= 2'h3;
			mbx1_q <= {`TPDF_HALF{1'b0}};
			mbx2_q <= {`TPDF_HALF{1'b0}};
			mailbox_one_new_flag_o <= 1'b0;
			mailbox_two_new_flag_o <= 1'b0;
			last_q   <= {`TPDF_WIDTH{1'b0}};
			last_v_q <= 1'b0;
			port_a_data_o      <= {`TPDF_WIDTH{1'b0}};
			port_a_data_oe_n_o <= 1'b1;
			port_b_data_o      <= {`TPDF_HALF{1'b0}};
		end else begin
			if (a_edge) begin
				fa1_q <= {room1, af1, rdy2, ae2};
				fa2_q <= fa1_q;
			end
			if (b_edge) begin
				fb1_q <= {rdy1, ae1};
				fb2_q <= fb1_q;
			end
			if (c_edge) begin
				fc1_q <= {room2, af2};
				fc2_q <= fc1_q;
			end
			if (a_mbx_wr)
				mbx1_q <= port_a_data_i[`TPDF_HALF-1:0];
			if (c_mbx_wr)
				mbx2_q <= port_c_data_i;
			// Storing wins over a same-cycle read
			mailbox_one_new_flag_o <= a_mbx_wr | (mailbox_one_new_flag_o & ~b_mbx_rd);
			mailbox_two_new_flag_o <= c_mbx_wr | (mailbox_two_new_flag_o & ~a_mbx_rd);
			if (init2 | shared2) begin
				last_v_q <= 1'b0;
			end else if (lp_pop) begin
				last_q   <= take2;
				last_v_q <= 1'b1;
			end
			port_a_data_oe_n_o <= ~a_read_dir;
			if (port_a_mailbox_i)
				port_a_data_o <= {{`TPDF_HALF{1'b0}}, mbx2_q};
			else if (!loop_select_i)
				port_a_data_o <= dout2;
			else if (lp_pop)
				port_a_data_o <= take2;
			if (port_b_mailbox_i)
				port_b_data_o <= mbx1_q;
			else
				port_b_data_o <= big_q ? dout1[`TPDF_WIDTH-1:`TPDF_HALF]
					: dout1[`TPDF_HALF-1:0];
		end
	end
endmodule // tpdf_top

`default_nettype wire

//--- core/tpdf_defines.vh
// Constants for the triple-port dual FIFO block
`ifndef TPDF_DEFINES_VH
`define TPDF_DEFINES_VH

`define TPDF_WIDTH      36
`define TPDF_HALF       18
`define TPDF_DEPTH      12'h800
`define TPDF_AW         11
`define TPDF_CW         12

// Offset-select codes {bit2,bit1,bit0}
`define TPDF_FS_8       3'h0
`define TPDF_FS_16      3'h1
`define TPDF_FS_64      3'h2
`define TPDF_FS_256     3'h3
`define TPDF_FS_1024    3'h4
`define TPDF_FS_SERIAL  3'h5

`define TPDF_OFF_8      12'h008
`define TPDF_OFF_16     12'h010
`define TPDF_OFF_64     12'h040
`define TPDF_OFF_256    12'h100
`define TPDF_OFF_1024   12'h400

// Programming steps: four parallel words or 48 serial bits
`define TPDF_PAR_STEPS  6'h04
`define TPDF_SER_STEPS  6'h30

`endif

//--- tb/tpdf_port_clock.sv
// Port-side partner: free-running bus clock of one port's processor
`default_nettype none
module tpdf_port_clock #(
	parameter int HALF = 8
) (
	input  wire logic clock_i,
	output var  logic port_clk_o
);
	timeunit 1ns;
	timeprecision 100ps;
	int count_q = 0;
	initial port_clk_o = 1'b0;
	// Continuous clock; each half must span at least five system cycles
	always @(posedge clock_i) begin
		count_q <= (count_q == HALF - 1) ? 0 : count_q + 1;
		if (count_q == HALF - 1)
			port_clk_o <= ~port_clk_o;
	end
endmodule // tpdf_port_clock
`default_nettype wire

//--- tb/tpdf_top_asserts.sv
// Checker on the ports of the triple-port dual FIFO
`default_nettype none
module tpdf_top_asserts (
	input wire logic clock_i,
	input wire logic reset_n_i,
	input wire logic full_init_first_queue_n_i,
	input wire logic flush_first_queue_n_i,
	input wire logic loop_select_i,
	input wire logic port_a_direction_i,
	input wire logic port_a_enable_i,
	input wire logic port_b_enable_i,
	input wire logic port_c_enable_i,
	input wire logic port_a_data_oe_n_o,
	input wire logic a_side_full_ready_o,
	input wire logic b_side_empty_ready_o,
	input wire logic b_side_almost_empty_o,
	input wire logic mailbox_one_new_flag_o,
	input wire logic mailbox_two_new_flag_o
);
	logic [7:0] idle_a_q;
	logic [7:0] idle_b_q;
	wire        init_one = !(full_init_first_queue_n_i && flush_first_queue_n_i);
	// Quiet time per port; flags lag by two port edges, so only long idles count
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			idle_a_q <= 8'h00;
			idle_b_q <= 8'h00;
		end else begin
			idle_a_q <= (init_one || port_a_enable_i || loop_select_i) ? 8'h00
				: idle_a_q + 8'(idle_a_q != 8'hFF);
			idle_b_q <= (init_one || port_b_enable_i) ? 8'h00 : idle_b_q + 8'(idle_b_q != 8'hFF);
		end
	end
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!reset_n_i);
	property p_oe_write; port_a_direction_i [*3] |-> port_a_data_oe_n_o; endproperty
	a_oe_write: assert property (p_oe_write) else $error("A driven");
	property p_oe_read; !port_a_direction_i [*3] |-> !port_a_data_oe_n_o; endproperty
	a_oe_read: assert property (p_oe_read) else $error("A not driven");
	property p_mb1_set; !port_a_enable_i [*8] |-> !$rose(mailbox_one_new_flag_o); endproperty
	a_mb1_set: assert property (p_mb1_set) else $error("mb1 set");
	property p_mb1_clr; !port_b_enable_i [*8] |-> !$fell(mailbox_one_new_flag_o); endproperty
	a_mb1_clr: assert property (p_mb1_clr) else $error("mb1 clear");
	property p_mb2_set; !port_c_enable_i [*8] |-> !$rose(mailbox_two_new_flag_o); endproperty
	a_mb2_set: assert property (p_mb2_set) else $error("mb2 set");
	property p_mb2_clr; !port_a_enable_i [*8] |-> !$fell(mailbox_two_new_flag_o); endproperty
	a_mb2_clr: assert property (p_mb2_clr) else $error("mb2 clear");
	property p_a_full; idle_a_q >= 8'h64 |-> !$fell(a_side_full_ready_o); endproperty
	a_a_full: assert property (p_a_full) else $error("full fell");
	property p_b_empty; idle_b_q >= 8'h64 |-> !$fell(b_side_empty_ready_o); endproperty
	a_b_empty: assert property (p_b_empty) else $error("ready fell");
	property p_b_ae; idle_b_q >= 8'h64 |-> !$fell(b_side_almost_empty_o); endproperty
	a_b_ae: assert property (p_b_ae) else $error("almost empty fell");
endmodule // tpdf_top_asserts
bind tpdf_top tpdf_top_asserts u_asserts (.clock_i(clock_i), .reset_n_i(reset_n_i),
	.full_init_first_queue_n_i(full_init_first_queue_n_i),
	.flush_first_queue_n_i(flush_first_queue_n_i), .loop_select_i(loop_select_i),
	.port_a_direction_i(port_a_direction_i), .port_a_enable_i(port_a_enable_i),
	.port_b_enable_i(port_b_enable_i), .port_c_enable_i(port_c_enable_i),
	.port_a_data_oe_n_o(port_a_data_oe_n_o), .a_side_full_ready_o(a_side_full_ready_o),
	.b_side_empty_ready_o(b_side_empty_ready_o), .b_side_almost_empty_o(b_side_almost_empty_o),
	.mailbox_one_new_flag_o(mailbox_one_new_flag_o),
	.mailbox_two_new_flag_o(mailbox_two_new_flag_o));
`default_nettype wire

//--- tb/triple_port_dual_fifo_bench.sv
// Self-checking bench for the triple-port dual FIFO
`include "tpdf_defines.vh"
`default_nettype none
module triple_port_dual_fifo_bench;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct {logic [35:0] w; logic [17:0] b;} tpdf_row_t;
	logic        clock_i = 1'b0;
	logic        reset_n_i = 1'b0;
	logic        mr_n = 1'b1, rmode = 1'b0, ets = 1'b0, dir = 1'b1;
	logic        loop = 1'b0, par = 1'b0, ser_bit = 1'b0, ser_en = 1'b0;
	logic [1:0]  fl_n = 2'h3;
	logic [2:0]  fs = 3'h0, en = 3'h0, mb = 3'h0;
	logic [35:0] a_din = 36'h0;
	logic [17:0] c_din = 18'h0;
	wire  [2:0]  pclk;
	wire  [35:0] a_dout;
	wire  [17:0] b_dout;
	wire         a_oe_n, a_fr, a_af, a_er, a_ae, b_er, b_ae, c_fr, c_af, mb1, mb2;
	int          n_errors = 0, checks_done = 0, cycles = 0;
	tpdf_row_t   rows [4] = '{'{36'h987654321, 18'h14321}, '{36'h00003FFFF, 18'h3FFFF},
		'{36'hFFFFC0000, 18'h00000}, '{36'h5A5A5A5A5, 18'h1A5A5}};
	always #2 clock_i = ~clock_i;
	tpdf_port_clock #(.HALF(8))  u_pa (.clock_i(clock_i), .port_clk_o(pclk[0]));
	tpdf_port_clock #(.HALF(9))  u_pb (.clock_i(clock_i), .port_clk_o(pclk[1]));
	tpdf_port_clock #(.HALF(10)) u_pc (.clock_i(clock_i), .port_clk_o(pclk[2]));
	tpdf_top dut (.clock_i(clock_i), .reset_n_i(reset_n_i), .port_a_clk_i(pclk[0]),
		.port_b_clk_i(pclk[1]), .port_c_clk_i(pclk[2]), .full_init_first_queue_n_i(mr_n),
		.full_init_second_queue_n_i(mr_n), .flush_first_queue_n_i(fl_n[0]),
		.flush_second_queue_n_i(fl_n[1]), .replay_mode_select_i(rmode),
		.endian_timing_select_i(ets), .offset_select_bit0_i(fs[0]), .offset_select_bit1_i(fs[1]),
		.offset_select_bit2_i(fs[2]), .parity_select_i(par), .serial_offset_input_i(ser_bit),
		.serial_enable_i(ser_en), .loop_select_i(loop), .port_a_direction_i(dir),
		.port_a_enable_i(en[0]), .port_a_mailbox_i(mb[0]), .port_a_data_i(a_din),
		.port_a_data_o(a_dout), .port_a_data_oe_n_o(a_oe_n), .port_b_enable_i(en[1]),
		.port_b_mailbox_i(mb[1]), .port_b_data_o(b_dout), .port_c_enable_i(en[2]),
		.port_c_mailbox_i(mb[2]), .port_c_data_i(c_din), .a_side_full_ready_o(a_fr),
		.a_side_almost_full_o(a_af), .a_side_empty_ready_o(a_er), .a_side_almost_empty_o(a_ae),
		.b_side_empty_ready_o(b_er), .b_side_almost_empty_o(b_ae), .c_side_full_ready_o(c_fr),
		.c_side_almost_full_o(c_af), .mailbox_one_new_flag_o(mb1), .mailbox_two_new_flag_o(mb2));
	task automatic summarize();
		$display("Checks %0d, errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	always @(posedge clock_i) begin
		cycles++;
		if (cycles == 60000) begin
			n_errors++;
			summarize();
		end
	end
	task automatic chk(input logic [35:0] got, input logic [35:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic settle();
		repeat (60) @(posedge clock_i);
		#1;
	endtask
	// Controls held from before the port edge until well after it is taken
	// Raised in the low half, so the previous port edge is already taken
	task automatic xfer(input int p, input logic m, input logic [35:0] d);
		@(negedge pclk[p]);
		#1;
		a_din = d;
		c_din = d[17:0];
		en[p] = 1'b1;
		mb[p] = m;
		@(posedge pclk[p]);
		repeat (8) @(posedge clock_i);
		#1;
		en = 3'h0;
		mb = 3'h0;
	endtask
	task automatic mreset(input logic [2:0] f, input logic be, input logic std);
		@(posedge clock_i);
		#1;
		fs = f;
		ets = be;
		mr_n = 1'b0;
		repeat (8) @(posedge clock_i);
		#1;
		mr_n = 1'b1;
		repeat (8) @(posedge clock_i);
		#1;
		ets = std;
		settle();
	endtask
	task automatic flush(input logic rep);
		@(posedge clock_i);
		#1;
		rmode = rep;
		fl_n[0] = 1'b0;
		repeat (8) @(posedge clock_i);
		#1;
		fl_n[0] = 1'b1;
		repeat (8) @(posedge clock_i);
		#1;
		rmode = 1'b0;
		settle();
	endtask
	initial begin
		logic [17:0] held;
		repeat (8) @(posedge clock_i);
		#1;
		chk(a_fr, 1'b1);
		chk(b_er, 1'b0);
		chk(mb1 | mb2, 1'b0);
		reset_n_i = 1'b1;
		mreset(`TPDF_FS_8, 1'b0, 1'b0);
		foreach (rows[i]) begin
			xfer(0, 1'b0, rows[i].w);
			settle();
			chk(b_dout, rows[0].b);
			chk(b_er, 1'b1);
		end
		for (int i = 1; i < 5; i++) begin
			xfer(1, 1'b0, 36'h0);
			settle();
			if (i < 4)
				chk(b_dout, rows[i].b);
		end
		chk(b_er, 1'b0);
		for (int i = 0; i < 10; i++) begin
			xfer(0, 1'b0, rows[i % 4].w);
			if (i == 7 || i == 9) begin
				settle();
				chk(b_ae, i == 9);
			end
		end
		flush(1'b0);
		chk(b_er, 1'b0);
		xfer(0, 1'b0, rows[1].w);
		settle();
		chk(b_dout, rows[1].b);
		xfer(0, 1'b1, rows[3].w);
		settle();
		chk(mb1, 1'b1);
		xfer(1, 1'b1, 36'h0);
		settle();
		// Mailbox word shows only while the mailbox select stands
		mb[1] = 1'b1;
		settle();
		chk(b_dout, rows[3].b);
		chk(mb1, 1'b0);
		mb[1] = 1'b0;
		xfer(2, 1'b1, rows[3].w);
		settle();
		chk(mb2, 1'b1);
		dir = 1'b0;
		xfer(0, 1'b1, 36'h0);
		settle();
		mb[0] = 1'b1;
		settle();
		chk(a_dout, {18'h0, rows[3].b});
		chk(a_oe_n, 1'b0);
		chk(mb2, 1'b0);
		mb[0] = 1'b0;
		dir = 1'b1;
		mreset(`TPDF_FS_16, 1'b1, 1'b1);
		held = b_dout;
		xfer(0, 1'b0, rows[0].w);
		settle();
		chk(b_er, 1'b1);
		chk(b_dout, held);
		for (int i = 0; i < 2; i++) begin
			xfer(1, 1'b0, 36'h0);
			settle();
			chk(b_dout, rows[0].w[35:18]);
			chk(b_er, 1'b0);
			flush(1'b1);
			chk(b_er, 1'b1);
		end
		par = 1'b1;
		mreset(3'h6, 1'b0, 1'b0);
		// Four offset words with junk on bit 8, then three queue words
		for (int i = 0; i < 7; i++) begin
			xfer(0, 1'b0, (i < 4) ? 36'h102 : rows[i - 4].w);
			if (i > 4) begin
				settle();
				chk(b_ae, i == 6);
			end
		end
		chk(b_dout, rows[0].b);
		flush(1'b0);
		xfer(2, 1'b0, rows[3].w);
		settle();
		chk(a_er, 1'b1);
		chk(a_ae, 1'b0);
		chk({c_fr, c_af, a_af}, 3'h7);
		dir = 1'b0;
		loop = 1'b1;
		repeat (100) @(posedge clock_i);
		#1;
		loop = 1'b0;
		settle();
		chk(a_dout, {18'h0, rows[3].b});
		chk(a_er, 1'b0);
		chk(b_dout, rows[3].b);
		chk(b_ae, 1'b1);
		dir = 1'b1;
		mreset(`TPDF_FS_SERIAL, 1'b0, 1'b0);
		// Zeros shifted in give all offsets zero
		ser_en = 1'b1;
		repeat (900) @(posedge clock_i);
		#1;
		ser_en = 1'b0;
		xfer(0, 1'b0, rows[1].w);
		settle();
		chk(b_ae, 1'b1);
		chk(b_dout, rows[1].b);
		repeat (150) @(posedge clock_i);
		summarize();
	end
endmodule // triple_port_dual_fifo_bench
`default_nettype wire
